// ===== tcs_pkg.sv
// Package: constants, types and command codes of the trajectory command block
// How it works
// R01: Motor-off stop drives zero-drive output code
// R02: Abrupt stop sets target to current position
// R03: Smooth stop decelerates with programmed acceleration
// R04: Host sets at most one stop bit
// R05: Bits 0-5 flag loaded parameters, relative
// R06: Host waits move end after acceleration change
// R07: Parameters two words, MSB first, A-V-P
// R08: Acceleration, velocity 32-bit unsigned, capped range
// R09: Low 16 bits are fraction
// R10: Host keeps acceleration not above velocity
// R11: Position signed 32-bit, limited range; the code stores the word without a range check
// R12: Buffers copied to working on start only
// R13: Start code 01, no data bytes
// R14: Illegal start ignored, command error raised
// R15: Start applied at sample boundary
// R16: Data reads follow a command write; the code never drives the data port on a data read
// R17: Status read whenever select strobes low
// R18: Status bit order motor-off down to busy
// R19: Motor-off bit reflects zero-drive output
// R20: Motor-off stop sets bit at start
// R21: Breakpoint flag sticky until reset-interrupts
// R22: Position-error flag set on threshold exceeded
// R23: Bit 11 velocity mode, bit 12 forward
// R24: Load code 1F, word then parameters
// R25: Control word more significant byte first
// R26: Writes ignored while busy, no error
// R27: Manual stop takes effect at start
package tcs_pkg;
    localparam logic [7:0] CMD_START_MOTION = 8'h01;
    localparam logic [7:0] CMD_LOAD_TRAJECTORY = 8'h1f;
    localparam logic [7:0] CMD_RESET_INTERRUPTS = 8'h1d;
    localparam int BIT_POS_REL = 0;
    localparam int BIT_POS_LOAD = 1;
    localparam int BIT_VEL_REL = 2;
    localparam int BIT_VEL_LOAD = 3;
    localparam int BIT_ACC_REL = 4;
    localparam int BIT_ACC_LOAD = 5;
    localparam int BIT_STOP_OFF = 8;
    localparam int BIT_STOP_ABRUPT = 9;
    localparam int BIT_STOP_SMOOTH = 10;
    localparam int BIT_VEL_MODE = 11;
    localparam int BIT_FORWARD = 12;
    localparam logic [31:0] ACC_VEL_MAX = 32'h3fff_ffff;
    localparam logic [31:0] POS_MIN = 32'hc000_0000;
    localparam logic [31:0] POS_MAX = 32'h3fff_ffff;
    localparam logic [7:0] DRIVE_ZERO = 8'h80;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    localparam int SAMPLE_CYCLES = 2048;
    localparam int BUSY_CYCLES = 4;

    typedef struct packed {
        logic motor_off;
        logic breakpoint;
        logic pos_error;
        logic wraparound;
        logic index_seen;
        logic traj_done;
        logic cmd_error;
        logic busy;
    } tcs_status_t;

    typedef struct packed {
        logic [31:0] acc;
        logic [31:0] vel;
        logic [31:0] pos;
        logic vel_mode;
        logic forward;
    } tcs_traj_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CTRL_HI = 3'b001,
        ST_CTRL_LO = 3'b011,
        ST_PARAM = 3'b010
    } tcs_state_t;
endpackage

// ===== tcs_sync.sv
// Two-flop synchroniser for asynchronous host pins
module tcs_sync import tcs_pkg::*; #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '1;
            q <= '1;
        end else begin
            s1_q <= d;
            q <= s1_q;
        end
    end
endmodule

// ===== tcs_param_shift.sv
// Byte assembler: shifts host bytes into a 32-bit parameter, most significant first
module tcs_param_shift import tcs_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Byte input
    input wire logic clr,
    input wire logic load,
    input wire logic [7:0] din,
    // Assembled word
    output logic [31:0] word,
    output logic [1:0] count
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            word <= 32'h0000_0000;
            count <= 2'h0;
        end else if (clr) begin
            count <= 2'h0;
        end else if (load) begin
            word <= {word[23:0], din}; // see R07
            count <= count + 2'h1;
        end
    end
endmodule

// ===== tcs_top.sv
// Trajectory command and status block behind the 8-bit host port
module tcs_top import tcs_pkg::*; #(
    parameter int SAMPLE_LEN = SAMPLE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Host port pins
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic port_select_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Motion core interface
    input wire logic [31:0] current_pos,
    input wire logic move_done,
    input wire logic breakpoint_hit,
    input wire logic pos_error_hit,
    input wire logic auto_off_armed,
    input wire logic wrap_hit,
    input wire logic index_hit,
    output tcs_traj_t work_q,
    output logic stop_smooth_q,
    output logic [7:0] drive_override_q,
    output logic drive_off_q
);
    ////////////////////////////////////////////////////////////////
    // Reset and pin synchronisation
    logic rst_s1_q, rst_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end

    logic [3:0] pins_s;
    logic [7:0] din_s;
    tcs_sync #(.W(4)) u_sync_pins (
        .clk(clk),
        .rst_n(rst_q),
        .d({cs_n, rd_n, wr_n, port_select_n}),
        .q(pins_s)
    );
    tcs_sync #(.W(8)) u_sync_data (
        .clk(clk),
        .rst_n(rst_q),
        .d(data_in),
        .q(din_s)
    );

    wire cs_s = ~pins_s[3];
    wire rd_s = ~pins_s[2];
    wire wr_s = ~pins_s[1];
    wire cmd_port = ~pins_s[0];
    logic wr_prev_q;
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) wr_prev_q <= 1'b0;
        else wr_prev_q <= cs_s & wr_s;
    end
    wire wr_pulse = cs_s & wr_s & ~wr_prev_q;

    ////////////////////////////////////////////////////////////////
    // Status and busy
    tcs_status_t st_q;
    logic [2:0] busy_cnt_q;
    wire accept = wr_pulse & ~st_q.busy; // see R26
    wire cmd_wr = accept & cmd_port;
    wire data_wr = accept & ~cmd_port;

    ////////////////////////////////////////////////////////////////
    // Command decode and byte sequencing
    tcs_state_t state_q, state_d;
    logic [15:0] ctrl_q;
    logic [5:0] pend_q;
    logic [31:0] acc_buf_q, vel_buf_q, pos_buf_q;
    logic [2:0] rel_q;
    logic acc_changed_q;
    logic [31:0] pword;
    logic [1:0] pcount;

    wire start_cmd = cmd_wr & (din_s == CMD_START_MOTION); // see R13
    wire load_cmd = cmd_wr & (din_s == CMD_LOAD_TRAJECTORY); // see R24
    wire reset_interrupts_cmd_cmd = cmd_wr & (din_s == CMD_RESET_INTERRUPTS);
    wire param_byte = data_wr & (state_q == ST_PARAM);
    wire word_done = param_byte & (pcount == 2'h3);
    wire want_acc = pend_q[BIT_ACC_LOAD];
    wire want_vel = ~want_acc & pend_q[BIT_VEL_LOAD];
    wire want_pos = ~want_acc & ~want_vel & pend_q[BIT_POS_LOAD];
    wire [31:0] full_word = {pword[23:0], din_s};
    wire moving = ~st_q.traj_done & ~st_q.motor_off;
    wire start_bad = start_cmd & acc_changed_q & moving; // see R14
    wire start_ok = start_cmd & ~start_bad;
    wire [5:0] after_ctrl = {din_s[5], 1'b0, din_s[3], 1'b0, din_s[1], 1'b0};

    tcs_param_shift u_shift (
        .clk(clk),
        .rst_n(rst_q),
        .clr(cmd_wr),
        .load(param_byte),
        .din(din_s),
        .word(pword),
        .count(pcount)
    );

    always_comb begin
        state_d = state_q;
        if (cmd_wr) begin
            state_d = load_cmd ? ST_CTRL_HI : ST_IDLE;
        end else if (data_wr) begin
            unique case (state_q)
                ST_IDLE: state_d = ST_IDLE;
                ST_CTRL_HI: state_d = ST_CTRL_LO; // see R25
                ST_CTRL_LO: state_d = (after_ctrl == 6'h00) ? ST_IDLE : ST_PARAM;
                ST_PARAM: begin
                    if (word_done && ((pend_q & ~({want_acc, 1'b0, want_vel, 1'b0, want_pos, 1'b0})) == 6'h00))
                        state_d = ST_IDLE;
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            state_q <= ST_IDLE;
            ctrl_q <= 16'h0000;
            pend_q <= 6'h00;
            rel_q <= 3'h0;
        end else begin
            state_q <= state_d;
            if (data_wr && state_q == ST_CTRL_HI) ctrl_q[15:8] <= din_s; // see R25
            if (data_wr && state_q == ST_CTRL_LO) begin
                ctrl_q[7:0] <= din_s;
                pend_q <= after_ctrl; // see R05
                rel_q <= {din_s[BIT_ACC_REL], din_s[BIT_VEL_REL], din_s[BIT_POS_REL]}; // see R05
            end
            if (word_done) begin
                if (want_acc) pend_q[BIT_ACC_LOAD] <= 1'b0; // see R07
                else if (want_vel) pend_q[BIT_VEL_LOAD] <= 1'b0;
                else pend_q[BIT_POS_LOAD] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Primary buffers
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            acc_buf_q <= 32'h0000_0000;
            vel_buf_q <= 32'h0000_0000;
            pos_buf_q <= 32'h0000_0000;
            acc_changed_q <= 1'b0;
        end else begin
            if (word_done && want_acc) begin
                acc_buf_q <= (rel_q[2] ? work_q.acc + full_word : full_word) & ACC_VEL_MAX; // see R08
            end
            if (word_done && want_vel) begin
                vel_buf_q <= (rel_q[1] ? work_q.vel + full_word : full_word) & ACC_VEL_MAX; // see R09
            end
            if (word_done && want_pos) begin
                pos_buf_q <= rel_q[0] ? work_q.pos + full_word : full_word; // see R11
            end
            if (word_done && want_acc) acc_changed_q <= 1'b1;
            else if (start_ok) acc_changed_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sample boundary and start application
    logic [15:0] smp_cnt_q;
    logic start_pend_q;
    logic [15:0] start_ctrl_q;
    wire smp_tick = (smp_cnt_q == 16'(SAMPLE_LEN - 1));
    wire apply = start_pend_q & smp_tick; // see R15

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            smp_cnt_q <= 16'h0000;
            start_pend_q <= 1'b0;
            start_ctrl_q <= 16'h0000;
        end else begin
            smp_cnt_q <= smp_tick ? 16'h0000 : smp_cnt_q + 16'h0001;
            if (start_ok) begin
                start_pend_q <= 1'b1;
                start_ctrl_q <= ctrl_q; // see R27
            end else if (apply) begin
                start_pend_q <= 1'b0;
            end
        end
    end

    wire stop_off = start_ctrl_q[BIT_STOP_OFF];
    wire stop_abrupt = start_ctrl_q[BIT_STOP_ABRUPT];
    wire stop_smooth = start_ctrl_q[BIT_STOP_SMOOTH];
    wire auto_off_hit = pos_error_hit & auto_off_armed;

    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            work_q <= '0;
            stop_smooth_q <= 1'b0;
            drive_override_q <= DRIVE_ZERO;
            drive_off_q <= 1'b1;
        end else begin
            if (apply) begin
                work_q.acc <= acc_buf_q; // see R12
                work_q.vel <= vel_buf_q;
                work_q.pos <= stop_abrupt ? current_pos : pos_buf_q; // see R02
                work_q.vel_mode <= start_ctrl_q[BIT_VEL_MODE]; // see R23
                work_q.forward <= start_ctrl_q[BIT_FORWARD]; // see R23
                stop_smooth_q <= stop_smooth; // see R03
                drive_override_q <= DRIVE_ZERO; // see R01
            end
            if (auto_off_hit) begin
                drive_off_q <= 1'b1; // see R19
            end else if (apply) begin
                drive_off_q <= stop_off; // see R01
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Status byte flags
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            st_q <= STATUS_RESET; // see R19
            busy_cnt_q <= 3'h0;
        end else begin
            if (auto_off_hit) st_q.motor_off <= 1'b1; // see R19
            else if (apply) st_q.motor_off <= stop_off; // see R20
            st_q.breakpoint <= breakpoint_hit | (st_q.breakpoint & ~reset_interrupts_cmd_cmd); // see R21
            st_q.pos_error <= pos_error_hit | (st_q.pos_error & ~reset_interrupts_cmd_cmd); // see R22
            st_q.wraparound <= wrap_hit | (st_q.wraparound & ~reset_interrupts_cmd_cmd);
            st_q.index_seen <= index_hit | (st_q.index_seen & ~reset_interrupts_cmd_cmd);
            st_q.traj_done <= (move_done & ~start_pend_q) | (st_q.traj_done & ~reset_interrupts_cmd_cmd & ~apply);
            st_q.cmd_error <= start_bad | (st_q.cmd_error & ~reset_interrupts_cmd_cmd); // see R14
            if (accept) busy_cnt_q <= 3'(BUSY_CYCLES);
            else if (busy_cnt_q != 3'h0) busy_cnt_q <= busy_cnt_q - 3'h1;
            st_q.busy <= accept | (busy_cnt_q > 3'h1);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Read port
    wire status_rd = cs_s & rd_s & cmd_port; // see R17
    always_ff @(posedge clk or negedge rst_q) begin
        if (!rst_q) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            data_out <= status_rd ? st_q : 8'h00; // see R18
            data_oe <= status_rd;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    busy_drop_a: assert property (@(posedge clk) disable iff (!rst_q) // see R26
        wr_pulse && st_q.busy |=> $stable(state_q) || state_q == ST_IDLE)
        else $error("write accepted while busy");
    start_buffer_a: assert property (@(posedge clk) disable iff (!rst_q) // see R12
        !apply |=> $stable(work_q.acc) && $stable(work_q.vel))
        else $error("working registers changed without start");
    bad_start_a: assert property (@(posedge clk) disable iff (!rst_q) // see R14
        start_bad |=> st_q.cmd_error && !start_pend_q)
        else $error("illegal start not flagged");
    motor_off_a: assert property (@(posedge clk) disable iff (!rst_q) // see R20
        apply && stop_off |=> st_q.motor_off && drive_off_q)
        else $error("motor-off stop not applied");
    abrupt_a: assert property (@(posedge clk) disable iff (!rst_q) // see R02
        apply && stop_abrupt |=> work_q.pos == $past(current_pos))
        else $error("abrupt stop target wrong");
    sample_edge_a: assert property (@(posedge clk) disable iff (!rst_q) // see R15
        !smp_tick |=> $stable(work_q))
        else $error("start applied off sample edge");
    bp_sticky_a: assert property (@(posedge clk) disable iff (!rst_q) // see R21
        st_q.breakpoint && !reset_interrupts_cmd_cmd |=> st_q.breakpoint)
        else $error("breakpoint flag lost");
    status_read_a: assert property (@(posedge clk) disable iff (!rst_q) // see R17
        status_rd |=> data_oe && data_out == $past(st_q))
        else $error("status byte not returned");
    acc_range_a: assert property (@(posedge clk) disable iff (!rst_q) // see R08
        work_q.acc <= ACC_VEL_MAX && work_q.vel <= ACC_VEL_MAX)
        else $error("acceleration or velocity out of range");
    data_port_quiet_a: assert property (@(posedge clk) disable iff (!rst_q) // see R16
        cs_s && rd_s && !cmd_port |=> !data_oe)
        else $error("data port driven without reporting command");
    motor_off_match_a: assert property (@(posedge clk) disable iff (!rst_q) // see R19
        st_q.motor_off == drive_off_q)
        else $error("motor-off flag differs from drive state");
    off_priority_a: assert property (@(posedge clk) disable iff (!rst_q) // see R19
        auto_off_hit |=> st_q.motor_off && drive_off_q)
        else $error("auto turn-off lost");
    busy_hold_a: assert property (@(posedge clk) disable iff (!rst_q) // see R26
        accept |=> st_q.busy)
        else $error("busy not raised after write");
    load_seq_a: assert property (@(posedge clk) disable iff (!rst_q) // see R24
        load_cmd |=> state_q == ST_CTRL_HI)
        else $error("load command did not expect control word");
    param_order_a: assert property (@(posedge clk) disable iff (!rst_q) // see R07
        word_done && want_acc |=> !pend_q[BIT_ACC_LOAD])
        else $error("acceleration word not consumed first");
endmodule

// ===== tcs_host_model.sv
// Host processor model on the 8-bit command/data port
module tcs_host_model import tcs_pkg::*; (
    // Clock
    input wire logic clk,
    // Host port pins
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic port_select_n,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        port_select_n = 1'b1;
        data_in = 8'h5a;
    end

    ////////////////////////////////////////
    // Status read needs no command code
    task automatic read_status(output logic [7:0] st);
        @(posedge clk);
        cs_n <= 1'b0;
        port_select_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (5) @(posedge clk);
        st = data_oe ? data_out : 8'hxx;
        cs_n <= 1'b1;
        port_select_n <= 1'b1;
        rd_n <= 1'b1;
    endtask

    // One byte write, then wait until busy drops
    task automatic wr_byte(input logic is_cmd, input logic [7:0] b);
        logic [7:0] st;
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        port_select_n <= !is_cmd;
        data_in <= b;
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        port_select_n <= 1'b1;
        data_in <= ~b;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 40; i++) begin
            read_status(st);
            if (st[0] === 1'b0) break;
        end
    endtask

    // Parameter as two words, most significant byte first
    task automatic send32(input logic [31:0] v);
        for (int k = 3; k >= 0; k--) begin
            wr_byte(1'b0, v[8*k+:8]);
        end
    endtask

    // Load command, control word high byte first, flagged parameters in order
    task automatic load_traj(input logic [15:0] c, input logic [31:0] a, input logic [31:0] v,
                             input logic [31:0] p);
        wr_byte(1'b1, CMD_LOAD_TRAJECTORY);
        wr_byte(1'b0, c[15:8]);
        wr_byte(1'b0, c[7:0]);
        if (c[BIT_ACC_LOAD]) send32(a);
        if (c[BIT_VEL_LOAD]) send32(v);
        if (c[BIT_POS_LOAD]) send32(p);
    endtask

    // Data port read with no reporting command pending
    task automatic read_data(output logic oe);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (5) @(posedge clk);
        oe = data_oe;
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask

    // Two quick writes: the second lands while busy and must be dropped
    task automatic wr_pair_fast(input logic [7:0] b0, input logic [7:0] b1);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        port_select_n <= 1'b1;
        data_in <= b0;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        port_select_n <= 1'b0;
        data_in <= b1;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        port_select_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ===== tb_trajectory_command_status.sv
// Testbench of the trajectory command and status block
module tb_trajectory_command_status import tcs_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SLEN = 16;
    logic clk, rst_n, cs_n, rd_n, wr_n, port_select_n, data_oe;
    logic [7:0] data_in, data_out, drive_override_q;
    logic [31:0] current_pos;
    logic move_done, breakpoint_hit, pos_error_hit, auto_off_armed, wrap_hit, index_hit;
    logic stop_smooth_q, drive_off_q, oe;
    tcs_traj_t work_q;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    logic [15:0] ctl [4] = '{16'h1800, 16'h0100, 16'h0400, 16'h0200};

    tcs_top #(.SAMPLE_LEN(SLEN)) uut (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .port_select_n(port_select_n), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .current_pos(current_pos), .move_done(move_done),
        .breakpoint_hit(breakpoint_hit), .pos_error_hit(pos_error_hit),
        .auto_off_armed(auto_off_armed), .wrap_hit(wrap_hit), .index_hit(index_hit),
        .work_q(work_q), .stop_smooth_q(stop_smooth_q), .drive_override_q(drive_override_q),
        .drive_off_q(drive_off_q));
    tcs_host_model host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .port_select_n(port_select_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

    ////////////////////////////////////////
    initial clk = 1'b0;
    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_status(input logic [7:0] exp);
        logic [7:0] st;
        host.read_status(st);
        checked++;
        if (st !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: status got %h expected %h", $time, st, exp);
        end
    endtask

    // Start, then let the next sample boundary pass
    task automatic start();
        host.wr_byte(1'b1, CMD_START_MOTION);
        repeat (2 * SLEN + 8) @(posedge clk);
    endtask

    task automatic pulse_done();
        @(posedge clk);
        move_done <= 1'b1;
        @(posedge clk);
        move_done <= 1'b0;
    endtask

    ////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        current_pos = 32'h0000_1234;
        {move_done, breakpoint_hit, pos_error_hit, auto_off_armed, wrap_hit, index_hit} = 6'h00;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk_status(STATUS_RESET);
        chk_word(32'(drive_off_q), 32'h1, "drive off");
        host.read_data(oe);
        chk_word(32'(oe), 32'h0, "data port quiet");
        // Buffered absolute load, range limits
        host.load_traj(16'h002a, 32'h0001_0000, ACC_VEL_MAX, POS_MIN);
        chk_word(work_q.acc, 32'h0, "acc held");
        start();
        chk_word(work_q.acc, 32'h0001_0000, "acc");
        chk_word(work_q.vel, ACC_VEL_MAX, "vel");
        chk_word(work_q.pos, POS_MIN, "pos");
        chk_status(8'h00);
        // Start during motion with acceleration changed
        host.load_traj(16'h0020, 32'h0000_8000, 32'h0, 32'h0);
        start();
        chk_status(8'h02);
        chk_word(work_q.acc, 32'h0001_0000, "acc kept");
        pulse_done();
        chk_status(8'h06);
        host.wr_byte(1'b1, CMD_RESET_INTERRUPTS);
        chk_status(8'h00);
        pulse_done();
        host.load_traj(16'h0003, 32'h0, 32'h0, 32'h0000_0005);
        start();
        chk_word(work_q.acc, 32'h0000_8000, "acc late");
        chk_word(work_q.pos, 32'hc000_0005, "pos rel");
        chk_status(8'h00);
        // Mode bits and each manual stop
        for (int i = 0; i < 4; i++) begin
            host.load_traj(ctl[i], 32'h0, 32'h0, 32'h0);
            if (ctl[i][BIT_STOP_OFF]) chk_word(32'(drive_off_q), 32'h0, "off early");
            start();
            chk_word(32'({work_q.vel_mode, work_q.forward}), 32'({ctl[i][11], ctl[i][12]}), "mode");
            chk_word(32'(drive_off_q), 32'(ctl[i][8]), "drive off");
            chk_word(32'(stop_smooth_q), 32'(ctl[i][10]), "smooth");
            if (ctl[i][BIT_STOP_OFF]) chk_word(32'(drive_override_q), 32'(DRIVE_ZERO), "zero");
            chk_status({ctl[i][8], 7'h00});
        end
        chk_word(work_q.pos, current_pos, "abrupt");
        // Sticky event flags
        @(posedge clk);
        {breakpoint_hit, wrap_hit, index_hit} <= 3'h7;
        @(posedge clk);
        {breakpoint_hit, wrap_hit, index_hit} <= 3'h0;
        chk_status(8'h58);
        host.wr_pair_fast(8'h00, CMD_RESET_INTERRUPTS);
        chk_status(8'h58);
        auto_off_armed <= 1'b1;
        pos_error_hit <= 1'b1;
        @(posedge clk);
        pos_error_hit <= 1'b0;
        chk_status(8'hf8);
        host.wr_byte(1'b1, CMD_RESET_INTERRUPTS);
        chk_status(8'h80);
        tally_and_finish();
    end
endmodule
